// >>> src/cbd_pkg.sv
package cbd_pkg;
   // Register offsets on the microcontroller port
   localparam logic [7:0] OFS_HDR_MIN    = 8'h30;
   localparam logic [7:0] OFS_HDR_SEC    = 8'h31;
   localparam logic [7:0] OFS_HDR_FRAME  = 8'h32;
   localparam logic [7:0] OFS_HDR_MODE   = 8'h33;
   localparam logic [7:0] OFS_SUBH_FILE  = 8'h34;
   localparam logic [7:0] OFS_SUBH_CHAN  = 8'h35;
   localparam logic [7:0] OFS_SUBH_SMODE = 8'h36;
   localparam logic [7:0] OFS_SUBH_CODE  = 8'h37;
   localparam logic [7:0] OFS_BLK_ADDR   = 8'h38;
   localparam logic [7:0] OFS_RSVD       = 8'h39;
   localparam logic [7:0] OFS_MODE_CTL   = 8'h3A;
   localparam logic [7:0] OFS_CORR_CTL   = 8'h3B;

   // Mode control fields
   localparam int MC_SUBCODE_WATCH = 5;
   localparam int MC_AUDIO_BUF     = 4;
   localparam int MC_CORR_REQ      = 3;
   localparam int MC_BUF_WRITE     = 2;
   localparam int MC_DECODE_EN     = 1;
   localparam int MC_DESCR_EN      = 0;
   localparam logic [7:0] MC_MASK  = 8'h3F;

   // Correction control fields
   localparam int CC_EXT_FORMAT = 7;
   localparam int CC_EDC_EN     = 3;
   localparam int CC_P_EN       = 2;
   localparam int CC_Q_EN       = 1;
   localparam int CC_ERASURE    = 0;
   localparam logic [7:0] CC_MASK = 8'h8F;

   localparam logic [7:0] MODE_CTL_RST = 8'h00;
   localparam logic [7:0] CORR_CTL_RST = 8'h00;
   localparam logic [7:0] BLK_ADDR_RST = 8'h00;
   localparam logic [7:0] HDR_RST      = 8'h00;

   // Block layout in bytes
   localparam logic [11:0] BLK_LAST    = 12'h92F;
   localparam logic [11:0] HDR_FIRST   = 12'h00C;
   localparam logic [11:0] HDR_LAST    = 12'h013;
   localparam logic [14:0] SCR_SEED    = 15'h0001;

   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 4;

   typedef enum logic [7:0] {
      CBD_STOP    = 8'h01,
      CBD_MONITOR = 8'h02,
      CBD_BUFONLY = 8'h04,
      CBD_ECC     = 8'h08,
      CBD_TEST    = 8'h10,
      CBD_AUDIO   = 8'h20,
      CBD_SUBCODE_WATCH_ENABLE  = 8'h40,
      CBD_INVALID = 8'h80
   } cbd_mode_t;

   typedef struct packed {
      logic ext_format_mode;
      logic edc_enable;
      logic p_parity_enable;
      logic q_parity_enable;
      logic erasure_correction_enable;
   } cbd_corr_cfg_t;
endpackage

// >>> src/cbd_decoder.sv
// Function
// [R1] Header minute/second/frame/mode in read-only registers
// [R2] Firmware reads header only after block interrupt
// [R3] Four subheader bytes in read-only registers
// [R4] Read/write register tracks current buffer block
// [R5] All mode bits zero: stop, nothing done
// [R6] Decode plus descramble only: monitor mode
// [R7] Add buffer write: buffering-only mode
// [R8] Add correction request: error-correction mode
// [R9] Buffer write, decode, no descramble: test mode
// [R10] Audio write alone: buffer raw audio data
// [R11] Subcode watch alone: subcode monitor mode
// [R12] Firmware sets main channel select first
// [R13] Correction request with decode, write: ECC
// [R14] Buffer write with decode activates buffering
// [R15] Decode enable processes incoming stream
// [R16] Descramble bit applies or bypasses descrambler
// [R17] Extended format bit selects block format
// [R18] EDC check runs after correction completes
// [R19] P parity enable drives P correction
// [R20] Q parity enable drives Q correction
// [R21] Erasure enable selects use of error flags
// [R22] Main channel select gates data buffering
// [R23] Undefined mode bit patterns buffer nothing
// [R24] Registers and interrupt update at block end
`timescale 1ns/1ns

module cbd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] head_reg;
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW-1:0]    rd_ptr_next;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             valid_reg;
   logic             push;
   logic             pop;

   assign in_ready    = (count_reg != FULL_CNT);
   assign out_valid   = valid_reg;
   assign out_data    = head_reg;
   assign push        = in_valid && in_ready;
   assign pop         = valid_reg && out_ready;
   assign rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
   assign count_next  = (AW+1)'(count_reg + (AW+1)'(push)
                      - (AW+1)'(pop));

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Head and valid are flops so the outputs carry no decode;
   // a push into an empty FIFO is forwarded straight to the head
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         valid_reg  <= 1'b0;
         head_reg   <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
         end
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         valid_reg  <= (count_next != '0);
         head_reg   <= (push && wr_ptr_reg == rd_ptr_next)
                     ? in_data : mem_reg[rd_ptr_next];
      end
   end
endmodule

module cbd_decoder
   import cbd_pkg::*;
(
   input  wire logic     mclk,
   input  wire logic     nrst,
   input  wire logic [7:0] mcu_addr,
   input  wire logic [7:0] mcu_wdata,
   input  wire logic     mcu_wr,
   input  wire logic     mcu_rd,
   output logic [7:0]    mcu_rdata,
   input  wire logic     dsp_bck,
   input  wire logic     dsp_sdata,
   input  wire logic     dsp_bsync,
   input  wire logic     main_chan_sel,
   input  wire logic     ecc_done,
   output logic [7:0]    buf_data,
   output logic          buf_valid,
   input  wire logic     buf_ready,
   output logic          drop_pulse,
   output logic          block_irq,
   output logic          ecc_start,
   output logic          edc_start,
   output logic          descr_active,
   output cbd_mode_t     dec_mode,
   output cbd_corr_cfg_t corr_cfg
);
   function automatic cbd_mode_t decode_mode(input logic [7:0] c);
      logic [5:0] b;
      b = c[5:0];
      casez (b)
         6'b01????: decode_mode = CBD_AUDIO;
         6'b10????: decode_mode = CBD_SUBCODE_WATCH_ENABLE;
         6'b000000: decode_mode = CBD_STOP;
         6'b000011: decode_mode = CBD_MONITOR;
         6'b000111: decode_mode = CBD_BUFONLY;
         6'b001111: decode_mode = CBD_ECC;
         6'b000110: decode_mode = CBD_TEST;
         default:   decode_mode = CBD_INVALID;
      endcase
   endfunction

   // Returns next descrambler state and the key byte, LSB first
   function automatic logic [22:0] scr_step(input logic [14:0] s);
      logic [14:0] st;
      logic [7:0]  key;
      st  = s;
      key = '0;
      for (int i = 0; i < 8; i++) begin
         key[i] = st[0];
         st     = {st[0] ^ st[1], st[14:1]};
      end
      scr_step = {st, key};
   endfunction

   logic [7:0]    mode_ctl_reg;
   logic [7:0]    corr_ctl_reg;
   logic [7:0]    blk_addr_reg;
   logic [7:0]    hdr_reg [8];
   logic [7:0]    shadow_reg [8];
   logic [7:0]    rdata_reg;
   cbd_mode_t     mode_reg;
   logic [2:0]    bck_sync_reg;
   logic [2:0]    sdat_sync_reg;
   logic [2:0]    bsync_sync_reg;
   logic          bck_q_reg;
   logic          bsync_q_reg;
   logic [2:0]    bit_cnt_reg;
   logic [7:0]    shift_reg;
   logic [11:0]   pos_cnt_reg;
   logic          byte_stb_reg;
   logic [7:0]    byte_reg;
   logic [11:0]   byte_pos_reg;
   logic [14:0]   scr_reg;
   logic          irq_reg;
   logic          ecc_start_reg;
   logic          edc_start_reg;
   logic          drop_reg;
   logic          descr_reg;
   logic          sel_sync_reg;

   logic          bck_rise;
   logic          bsync_rise;
   logic          decoding;
   logic          buffering;
   logic          blk_end;
   logic          hdr_byte;
   logic [22:0]   scr_next;
   logic [7:0]    proc_byte;
   logic          fifo_in_ready;
   logic          fifo_push;
   logic          bus_wr;
   cbd_mode_t     mode_next;

   // Register writes
   assign bus_wr = mcu_wr;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_ctl_reg <= MODE_CTL_RST;
         corr_ctl_reg <= CORR_CTL_RST;
      end else if (bus_wr) begin
         if (mcu_addr == OFS_MODE_CTL) begin
            mode_ctl_reg <= mcu_wdata & MC_MASK;
         end
         if (mcu_addr == OFS_CORR_CTL) begin
            corr_ctl_reg <= mcu_wdata & CC_MASK;
         end
      end
   end

   // Mode changes take effect one clock after the control write
   assign mode_next = decode_mode(mode_ctl_reg);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= CBD_STOP;
      end else begin
         mode_reg <= mode_next; // R5 R6 R7 R8 R9 R10 R11 R13 R14 R23
      end
   end

   assign decoding  = (mode_reg == CBD_MONITOR) || (mode_reg == CBD_BUFONLY)
                   || (mode_reg == CBD_ECC) || (mode_reg == CBD_TEST); // R15
   // Invalid, stop, monitor and subcode watch never buffer
   assign buffering = ((mode_reg == CBD_BUFONLY) || (mode_reg == CBD_ECC)
                   || (mode_reg == CBD_TEST) || (mode_reg == CBD_AUDIO))
                   && sel_sync_reg; // R7 R10 R14 R22 R23

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sel_sync_reg <= 1'b0;
      end else begin
         sel_sync_reg <= main_chan_sel; // R22
      end
   end

   // Serial stream pins are asynchronous; a bit clock or block sync level counts when the
   // second and third stages agree
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bck_sync_reg   <= '0;
         sdat_sync_reg  <= '0;
         bsync_sync_reg <= '0;
         bck_q_reg      <= 1'b0;
         bsync_q_reg    <= 1'b0;
      end else begin
         bck_sync_reg   <= {bck_sync_reg[1:0], dsp_bck};
         sdat_sync_reg  <= {sdat_sync_reg[1:0], dsp_sdata};
         bsync_sync_reg <= {bsync_sync_reg[1:0], dsp_bsync};
         if (bck_sync_reg[1] == bck_sync_reg[2]) begin
            bck_q_reg <= bck_sync_reg[2];
         end
         if (bsync_sync_reg[1] == bsync_sync_reg[2]) begin
            bsync_q_reg <= bsync_sync_reg[2];
         end
      end
   end

   assign bck_rise   = (bck_sync_reg[1] == bck_sync_reg[2])
                    && bck_sync_reg[2] && !bck_q_reg;
   assign bsync_rise = (bsync_sync_reg[1] == bsync_sync_reg[2])
                    && bsync_sync_reg[2] && !bsync_q_reg;

   // Byte assembly, MSB first; block sync realigns bits and bytes
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_reg  <= '0;
         shift_reg    <= '0;
         pos_cnt_reg  <= '0;
         byte_stb_reg <= 1'b0;
         byte_reg     <= '0;
         byte_pos_reg <= '0;
      end else begin
         byte_stb_reg <= 1'b0;
         if (bsync_rise || mode_reg == CBD_STOP) begin // R5
            bit_cnt_reg <= '0;
            pos_cnt_reg <= '0;
         end else if (bck_rise) begin
            shift_reg   <= {shift_reg[6:0], sdat_sync_reg[2]};
            bit_cnt_reg <= 3'(bit_cnt_reg + 1'b1);
            if (bit_cnt_reg == 3'h7) begin
               byte_stb_reg <= 1'b1;
               byte_reg     <= {shift_reg[6:0], sdat_sync_reg[2]};
               byte_pos_reg <= pos_cnt_reg;
               pos_cnt_reg  <= (pos_cnt_reg == BLK_LAST) ? 12'h000
                             : 12'(pos_cnt_reg + 1'b1);
            end
         end
      end
   end

   // Descrambler covers every byte after the sync field
   assign scr_next = scr_step(scr_reg);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scr_reg   <= SCR_SEED;
         descr_reg <= 1'b0;
      end else begin
         // Follows the decoded mode, not the raw bit, so it never runs
         // ahead of a mode change still in flight
         descr_reg <= (mode_reg == CBD_MONITOR)
                   || (mode_reg == CBD_BUFONLY)
                   || (mode_reg == CBD_ECC); // R16
         if (byte_stb_reg) begin
            if (byte_pos_reg < HDR_FIRST) begin
               scr_reg <= SCR_SEED;
            end else begin
               scr_reg <= scr_next[22:8];
            end
         end
      end
   end

   // Audio data is raw and never descrambled
   assign proc_byte = (descr_reg && byte_pos_reg >= HDR_FIRST)
                    ? (byte_reg ^ scr_next[7:0]) : byte_reg; // R16 R9

   assign hdr_byte  = byte_stb_reg && decoding
                   && byte_pos_reg >= HDR_FIRST && byte_pos_reg <= HDR_LAST;
   assign blk_end   = byte_stb_reg && byte_pos_reg == BLK_LAST
                   && (decoding || mode_reg == CBD_AUDIO);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 8; i++) begin
            shadow_reg[i] <= HDR_RST;
         end
      end else if (hdr_byte) begin
         shadow_reg[3'(byte_pos_reg - HDR_FIRST)] <= proc_byte;
      end
   end

   // Committed only at block end so firmware never sees a torn header
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 8; i++) begin
            hdr_reg[i] <= HDR_RST;
         end
      end else if (blk_end && decoding) begin
         for (int i = 0; i < 8; i++) begin
            hdr_reg[i] <= shadow_reg[i]; // R1 R3 R24
         end
      end
   end

   // Firmware write wins over the hardware advance in the same cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         blk_addr_reg <= BLK_ADDR_RST;
      end else if (bus_wr && mcu_addr == OFS_BLK_ADDR) begin
         blk_addr_reg <= mcu_wdata; // R4
      end else if (blk_end && buffering) begin
         blk_addr_reg <= 8'(blk_addr_reg + 1'b1); // R4 R24
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_reg       <= 1'b0;
         ecc_start_reg <= 1'b0;
         edc_start_reg <= 1'b0;
      end else begin
         irq_reg       <= blk_end && decoding; // R24 R2
         ecc_start_reg <= blk_end && mode_reg == CBD_ECC; // R8 R13
         edc_start_reg <= ecc_done && corr_ctl_reg[CC_EDC_EN]; // R18
      end
   end

   // The serial stream cannot be stalled; a full FIFO drops the byte
   assign fifo_push = byte_stb_reg && buffering;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         drop_reg <= 1'b0;
      end else begin
         drop_reg <= fifo_push && !fifo_in_ready;
      end
   end

   cbd_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (proc_byte),
      .out_valid (buf_valid),
      .out_ready (buf_ready),
      .out_data  (buf_data)
   );

   // Read data is registered; unmapped and reserved bytes read zero
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= 8'h00;
      end else if (mcu_rd) begin
         case (mcu_addr)
            OFS_HDR_MIN:    rdata_reg <= hdr_reg[0]; // R1
            OFS_HDR_SEC:    rdata_reg <= hdr_reg[1]; // R1
            OFS_HDR_FRAME:  rdata_reg <= hdr_reg[2]; // R1
            OFS_HDR_MODE:   rdata_reg <= hdr_reg[3]; // R1
            OFS_SUBH_FILE:  rdata_reg <= hdr_reg[4]; // R3
            OFS_SUBH_CHAN:  rdata_reg <= hdr_reg[5]; // R3
            OFS_SUBH_SMODE: rdata_reg <= hdr_reg[6]; // R3
            OFS_SUBH_CODE:  rdata_reg <= hdr_reg[7]; // R3
            OFS_BLK_ADDR:   rdata_reg <= blk_addr_reg; // R4
            OFS_MODE_CTL:   rdata_reg <= mode_ctl_reg;
            OFS_CORR_CTL:   rdata_reg <= corr_ctl_reg;
            default:        rdata_reg <= 8'h00;
         endcase
      end
   end

   assign mcu_rdata    = rdata_reg;
   assign block_irq    = irq_reg;
   assign ecc_start    = ecc_start_reg;
   assign edc_start    = edc_start_reg;
   assign drop_pulse   = drop_reg;
   assign descr_active = descr_reg;
   assign dec_mode     = mode_reg;
   assign corr_cfg     = '{corr_ctl_reg[CC_EXT_FORMAT],
                           corr_ctl_reg[CC_EDC_EN],
                           corr_ctl_reg[CC_P_EN],
                           corr_ctl_reg[CC_Q_EN],
                           corr_ctl_reg[CC_ERASURE]}; // R17 R19 R20 R21

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence s_block_done;
      blk_end && decoding;
   endsequence

   sequence s_commit;
      irq_reg && hdr_reg[0] == $past(shadow_reg[0])
              && hdr_reg[7] == $past(shadow_reg[7]);
   endsequence

   a_stop_no_push: assert property (mode_reg == CBD_STOP |-> !fifo_push)
      else $error("stop mode pushed data"); // R5
   a_monitor_descr: assert property (mode_reg == CBD_MONITOR
      |-> !fifo_push ##1 descr_reg)
      else $error("monitor mode buffered or skipped descrambling"); // R6
   a_bufonly_push: assert property (mode_reg == CBD_BUFONLY && sel_sync_reg
      && byte_stb_reg |-> fifo_push)
      else $error("buffering-only mode dropped a byte"); // R7
   a_ecc_mode_dec: assert property (mode_ctl_reg[5:0] == 6'h0F
      |=> mode_reg == CBD_ECC)
      else $error("ecc mode not entered"); // R8
   a_test_no_descr: assert property (mode_reg == CBD_TEST |=> !descr_reg)
      else $error("test mode descrambled"); // R9
   a_audio_mode: assert property (mode_ctl_reg[5:4] == 2'b01
      |=> mode_reg == CBD_AUDIO)
      else $error("audio mode not entered"); // R10
   a_subcode_watch_enable_mode: assert property (mode_ctl_reg[5:4] == 2'b10
      |=> mode_reg == CBD_SUBCODE_WATCH_ENABLE && !buffering)
      else $error("subcode watch mode wrong"); // R11
   a_invalid_quiet: assert property (mode_reg == CBD_INVALID |-> !fifo_push)
      else $error("invalid mode buffered"); // R23
   a_chan_gate: assert property (!sel_sync_reg |-> !fifo_push)
      else $error("deselected channel buffered"); // R22
   a_block_commit: assert property (s_block_done |=> s_commit)
      else $error("header not committed with interrupt"); // R24
   a_edc_follow: assert property (ecc_done && corr_cfg.edc_enable
      |=> edc_start ##1 !edc_start || ecc_done)
      else $error("edc start not after ecc done"); // R18
endmodule

// >>> test/cbd_dsp_model.sv
`timescale 1ns/1ns

module cbd_dsp_model (
   input  wire logic mclk,
   output logic      bck,
   output logic      sdata,
   output logic      bsync
);
   initial begin
      bck = 1'b0;
      sdata = 1'b0;
      bsync = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Each byte carries its own position, so a gap shows at the far end
   // Bit clock stands still outside frames; phases of 3 cycles, one above the 2-cycle minimum
   task automatic send_frame(input int n);
      logic [7:0] b;
      b = 8'h00;
      bsync <= 1'b1;
      wait_clk(8);
      bsync <= 1'b0;
      wait_clk(8);
      for (int i = 0; i < n; i++) begin
         b = i[7:0];
         for (int k = 7; k >= 0; k--) begin
            sdata <= b[k];
            wait_clk(3);
            bck <= 1'b1;
            wait_clk(3);
            bck <= 1'b0;
         end
      end
      // Released line shows the inverse, never a stale copy of the last bit
      sdata <= ~b[0];
      wait_clk(8);
   endtask
endmodule

// >>> test/tb_cd_block_decoder_control.sv
`timescale 1ns/1ns

module tb_cd_block_decoder_control
   import cbd_pkg::*;
();
   logic          mclk = 1'b0;
   logic          nrst = 1'b0;
   logic [7:0]    mcu_addr = 8'h00;
   logic [7:0]    mcu_wdata = 8'h00;
   logic          mcu_wr = 1'b0;
   logic          mcu_rd = 1'b0;
   logic [7:0]    mcu_rdata;
   logic          bck;
   logic          sdata;
   logic          bsync;
   logic          main_chan_sel = 1'b0;
   logic          ecc_done = 1'b0;
   logic          buf_ready = 1'b1;
   logic [7:0]    buf_data;
   logic          buf_valid;
   logic          drop_pulse;
   logic          block_irq;
   logic          ecc_start;
   logic          edc_start;
   logic          descr_active;
   cbd_mode_t     dec_mode;
   cbd_corr_cfg_t corr_cfg;
   int            n_fail = 0;
   int            checked = 0;
   int            n_drop = 0;
   int            n_val = 0;
   int            n_irq = 0;
   int            n_edc = 0;
   int            n_ecc = 0;
   int            cyc = 0;
   logic [7:0]    last_pop = 8'h00;
   logic          seq_on = 1'b0;
   logic [7:0]    rd_val;
   logic [7:0]    mode_val [12] = '{8'h00, 8'h03, 8'h07, 8'h0F, 8'h06,
      8'h10, 8'h1F, 8'h20, 8'h2F, 8'h30, 8'h3F, 8'h0B};
   cbd_mode_t     mode_exp [12] = '{CBD_STOP, CBD_MONITOR, CBD_BUFONLY,
      CBD_ECC, CBD_TEST, CBD_AUDIO, CBD_AUDIO, CBD_SUBCODE_WATCH_ENABLE, CBD_SUBCODE_WATCH_ENABLE,
      CBD_INVALID, CBD_INVALID, CBD_INVALID};
   logic [7:0]    cc_val [5] = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h01};
   logic [7:0]    cc_exp [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

   always #2 mclk = ~mclk;

   cbd_decoder dut (.mclk(mclk), .nrst(nrst), .mcu_addr(mcu_addr),
      .mcu_wdata(mcu_wdata), .mcu_wr(mcu_wr), .mcu_rd(mcu_rd),
      .mcu_rdata(mcu_rdata), .dsp_bck(bck), .dsp_sdata(sdata),
      .dsp_bsync(bsync), .main_chan_sel(main_chan_sel),
      .ecc_done(ecc_done), .buf_data(buf_data), .buf_valid(buf_valid),
      .buf_ready(buf_ready), .drop_pulse(drop_pulse),
      .block_irq(block_irq), .ecc_start(ecc_start),
      .edc_start(edc_start), .descr_active(descr_active),
      .dec_mode(dec_mode), .corr_cfg(corr_cfg));

   cbd_dsp_model dsp (.mclk(mclk), .bck(bck), .sdata(sdata),
      .bsync(bsync));

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Bus tasks are entered just after a rising edge and leave on one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      mcu_addr <= a;
      mcu_wdata <= d;
      mcu_wr <= 1'b1;
      @(posedge mclk);
      mcu_wr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      mcu_addr <= a;
      mcu_rd <= 1'b1;
      @(posedge mclk);
      mcu_rd <= 1'b0;
      @(posedge mclk);
      #1 rd_val = mcu_rdata;
      chk($sformatf("reg %h", a), rd_val, exp);
      @(posedge mclk);
   endtask

   task automatic pulse_ecc_done;
      ecc_done <= 1'b1;
      @(posedge mclk);
      ecc_done <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   // A short frame in a mode or with a channel select that must not buffer anything
   task automatic quiet(input logic [7:0] m, input logic sel);
      wr(OFS_MODE_CTL, m);
      main_chan_sel <= sel;
      repeat (4) @(posedge mclk);
      n_val = 0;
      n_irq = 0;
      dsp.send_frame(12);
      chk("buffered", n_val[7:0], 8'h00);
      chk("irq_count", n_irq[7:0], 8'h00);
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (drop_pulse === 1'b1) n_drop++;
      if (block_irq === 1'b1) n_irq++;
      if (edc_start === 1'b1) n_edc++;
      if (ecc_start === 1'b1) n_ecc++;
      if (buf_valid === 1'b1) n_val++;
      if (buf_valid === 1'b1 && buf_ready === 1'b1) begin
         if (seq_on) chk("buf_order", buf_data, last_pop + 8'h01);
         last_pop = buf_data;
      end
      // One full block takes about 113000 cycles
      if (cyc == 160000) begin
         n_fail++;
         complete_run();
      end
   end

   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("mode_rst", dec_mode, CBD_STOP);
      rchk(OFS_MODE_CTL, MODE_CTL_RST);
      rchk(OFS_CORR_CTL, CORR_CTL_RST);
      rchk(OFS_BLK_ADDR, BLK_ADDR_RST);
      wr(OFS_RSVD, 8'hFF);
      rchk(OFS_RSVD, 8'h00);
      wr(8'h50, 8'hFF);
      rchk(8'h50, 8'h00);
      $display("test reset_and_map finished");
      main_chan_sel <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         wr(OFS_MODE_CTL, mode_val[i]);
         @(posedge mclk);
         #1 chk("mode", dec_mode, mode_exp[i]);
         @(posedge mclk);
      end
      wr(OFS_MODE_CTL, 8'hFF);
      rchk(OFS_MODE_CTL, 8'h3F);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CORR_CTL, cc_val[i]);
         #1 chk("corr_cfg", {3'h0, corr_cfg}, cc_exp[i]);
         @(posedge mclk);
      end
      wr(OFS_CORR_CTL, 8'hFF);
      rchk(OFS_CORR_CTL, 8'h8F);
      wr(OFS_CORR_CTL, 8'h08);
      n_edc = 0;
      pulse_ecc_done();
      wr(OFS_CORR_CTL, 8'h00);
      pulse_ecc_done();
      chk("edc_start", n_edc[7:0], 8'h01);
      $display("test mode_and_config finished");
      quiet(8'h00, 1'b1);
      quiet(8'h03, 1'b1);
      chk("descr_active", {7'h0, descr_active}, 8'h01);
      quiet(8'h06, 1'b0);
      quiet(8'h30, 1'b1);
      quiet(8'h20, 1'b1);
      $display("test no_buffering finished");
      wr(OFS_MODE_CTL, 8'h06);
      main_chan_sel <= 1'b1;
      wr(OFS_BLK_ADDR, 8'h10);
      rchk(OFS_BLK_ADDR, 8'h10);
      n_irq = 0;
      n_drop = 0;
      buf_ready <= 1'b0;
      // Stall the drain early so the FIFO fills and refuses bytes
      fork
         dsp.send_frame(2352);
         begin
            repeat (3000) @(posedge mclk);
            buf_ready <= 1'b1;
            repeat (400) @(posedge mclk);
            seq_on <= 1'b1;
         end
      join
      seq_on <= 1'b0;
      chk("drop_seen", (n_drop != 0) ? 8'h01 : 8'h00, 8'h01);
      chk("buf_valid", {7'h0, buf_valid}, 8'h00);
      chk("descr_active", {7'h0, descr_active}, 8'h00);
      chk("irq_count", n_irq[7:0], 8'h01);
      chk("ecc_start", n_ecc[7:0], 8'h00);
      for (int a = 0; a < 8; a++)
         rchk(OFS_HDR_MIN + a[7:0], 8'h0C + a[7:0]);
      rchk(OFS_BLK_ADDR, 8'h11);
      wr(OFS_HDR_MIN, 8'hFF);
      rchk(OFS_HDR_MIN, 8'h0C);
      $display("test full_block finished");
      complete_run();
   end
endmodule
